// [rtl/dbs_pkg.sv]
package dbs_pkg;
  localparam logic [6:0]  DEV_INFO_ADDR      = 7'h42;
  localparam logic [6:0]  BUS_COMM_ADDR      = 7'h43;
  localparam logic [15:0] STAT_RESET_VAL     = 16'h0000;
  localparam int          CRC_STAT_BIT       = 9;
  localparam int          CRC_FAIL_BIT       = 8;
  localparam int          PRIOR_HI           = 7;
  localparam int          PRIOR_LO           = 6;
  localparam int          DEV_MODE_BIT       = 4;
  localparam int          WD_CNT_HI          = 3;
  localparam int          WD_CNT_LO          = 2;
  localparam int          SPI_FAIL_BIT       = 1;
  localparam int          FAILURE_BIT        = 0;
  localparam int          CAN_TIMEOUT_FLAG_BIT          = 4;
  localparam int          SWERR_BIT          = 3;
  localparam int          CANFAIL_HI         = 2;
  localparam int          CANFAIL_LO         = 1;
  localparam int          VCANUV_BIT         = 0;
  localparam logic [1:0]  WD_CNT_MAX         = 2'h3;
  localparam logic [5:0]  SWK_ERR_LIMIT      = 6'h20;
  typedef enum logic [1:0] {
    DBS_PRIOR_CLEARED = 2'h0,
    DBS_PRIOR_RESTART = 2'h1,
    DBS_PRIOR_SLEEP   = 2'h2
  } dbs_prior_t;
  typedef enum logic [1:0] {
    DBS_CAN_OK      = 2'h0,
    DBS_CAN_TSD     = 2'h1,
    DBS_CAN_TXD_DOM = 2'h2,
    DBS_CAN_BUS_DOM = 2'h3
  } dbs_canfail_t;
  typedef enum logic [1:0] {
    DBS_TX_OFF     = 2'h0,
    DBS_TX_WAIT    = 2'h1,
    DBS_TX_ENABLED = 2'h3
  } dbs_tx_t;
endpackage : dbs_pkg

// [rtl/dbs_status_regs.sv]
`timescale 1ns/1ps
//Contract
// - Reserved bits 15:10 of device info status always read zero.
// - CRC bits readable always; device info read skips CRC check.
// - CRC failure sets flag, except the static CRC enable/disable sequence.
// - Prior-state: 00 cleared, 01 failure restart or fail-safe wake, 10 sleep.
// - Sleep attempt with wake flags still set also reports sleep code.
// - Development-mode bit mirrors mode, hardware-updated only.
// - Watchdog failure count saturates at 3, device clears it itself.
// - Invalid SPI command sets SPI failure; only SPI clears it.
// - Prior-state shows state held before leaving restart.
// - Time-out sets on silence while selective wake enabled, stays set.
// - Time-out raises interrupt in Normal/Stop when mask is one.
// - Time-out clear blocked until next falling edge of interrupt output.
// - Selective-wake error on config error or counter over 32, only when enabled.
// - CAN failure: 01 thermal, 10 transmit dominant, 11 bus dominant.
// - Supply undervoltage sets flag and disables transmitter while present.
// - Supply undervoltage compared only in normal or receive-only mode.
// - Transmit dominant time-out ends on data high, wake-capable or off.
// - Bus dominant time-out ends on recessive bus, wake-capable or off.
// - Undervoltage condition ends when supply rises above threshold.
// - After any fault transmit re-enables only after data high for enable time.
module dbs_status_regs
  import dbs_pkg::*;
#(
  parameter int TX_EN_CYCLES = 8
) (
  // Clock and resets
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        softReset,
  input  wire logic        restartReset,
  // Register read port
  input  wire logic        rdStb,
  input  wire logic [6:0]  rdAddr,
  input  wire logic        spiClrStb,
  output logic      [15:0] rdData,
  output logic             crcCheckSkip,
  // Device events
  input  wire logic        crcEnabled,
  input  wire logic        crcFailEvt,
  input  wire logic        crcStaticSeq,
  input  wire logic        failureEvt,
  input  wire logic        spiInvalidEvt,
  input  wire logic        wdFailEvt,
  input  wire logic        wdCountClr,
  input  wire logic        devModeActive,
  input  wire logic        restartExit,
  input  wire logic        fromSleep,
  input  wire logic        sleepWithFlags,
  // CAN side
  input  wire logic        selectiveWakeEnable,
  input  wire logic        canSilenceIndication,
  input  wire logic        canTimeoutIrqMask,
  input  wire logic        normalOrStop,
  input  wire logic        swkConfigErr,
  input  wire logic [5:0]  swkErrCount,
  input  wire logic        canTsd,
  input  wire logic        txdDomTimeout,
  input  wire logic        busDomTimeout,
  input  wire logic        txdHigh,
  input  wire logic        busRecessive,
  input  wire logic        canNormalOrRxOnly,
  input  wire logic        canWakeOrOff,
  input  wire logic        canSupplyBelowThr,
  input  wire logic        interruptFallEvt,
  output logic             canTimeoutIrq,
  output logic             canTxEnable
);

  logic        crcFail_r;
  logic [1:0]  prior_r;
  logic [1:0]  wdCnt_r;
  logic        spiFail_r;
  logic        failure_r;
  logic        can_timeout_flag_r;
  logic        toClrBlock_r;
  logic        swErr_r;
  logic [1:0]  canFail_r;
  logic        vcanUv_r;
  dbs_tx_t     txState_r;
  logic [7:0]  txCnt_r;
  logic        rdDev;
  logic        rdBus;
  logic        uvActive;
  logic        txdDomCond;
  logic        busDomCond;
  logic        anyFault;
  logic        clrDev;
  logic        clrBus;

  function automatic logic addrIs(input logic [6:0] a, input logic [6:0] target);
    return a == target;
  endfunction : addrIs

  assign rdDev = rdStb && addrIs(rdAddr, DEV_INFO_ADDR);
  assign rdBus = rdStb && addrIs(rdAddr, BUS_COMM_ADDR);
  assign clrDev = rdDev || (spiClrStb && addrIs(rdAddr, DEV_INFO_ADDR));
  assign clrBus = rdBus || (spiClrStb && addrIs(rdAddr, BUS_COMM_ADDR));
  assign crcCheckSkip = rdDev;
  assign uvActive = canNormalOrRxOnly && canSupplyBelowThr;
  assign txdDomCond = txdDomTimeout && !txdHigh && !canWakeOrOff;
  assign busDomCond = busDomTimeout && !busRecessive && !canWakeOrOff;
  assign anyFault = canTsd || txdDomCond || busDomCond || uvActive;
  assign canTimeoutIrq = can_timeout_flag_r && canTimeoutIrqMask && normalOrStop;
  assign canTxEnable = (txState_r == DBS_TX_ENABLED) && !anyFault;

  // Read data is registered; flags sampled before any same-cycle clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdData <= STAT_RESET_VAL;
    end else if (rdDev) begin
      rdData <= STAT_RESET_VAL;
      rdData[CRC_STAT_BIT] <= crcEnabled;
      rdData[CRC_FAIL_BIT] <= crcFail_r;
      rdData[PRIOR_HI:PRIOR_LO] <= prior_r;
      rdData[DEV_MODE_BIT] <= devModeActive;
      rdData[WD_CNT_HI:WD_CNT_LO] <= wdCnt_r;
      rdData[SPI_FAIL_BIT] <= spiFail_r;
      rdData[FAILURE_BIT] <= failure_r;
    end else if (rdBus) begin
      rdData <= STAT_RESET_VAL;
      rdData[CAN_TIMEOUT_FLAG_BIT] <= can_timeout_flag_r;
      rdData[SWERR_BIT] <= swErr_r;
      rdData[CANFAIL_HI:CANFAIL_LO] <= canFail_r;
      rdData[VCANUV_BIT] <= vcanUv_r;
    end else if (rdStb) begin
      // Unmapped reads return zero rather than the last word
      rdData <= STAT_RESET_VAL;
    end
  end

  // Device flags: set wins over clear; restart keeps these fields
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      crcFail_r <= 1'b0;
      spiFail_r <= 1'b0;
      failure_r <= 1'b0;
    end else if (softReset) begin
      crcFail_r <= 1'b0;
      spiFail_r <= 1'b0;
      failure_r <= 1'b0;
    end else begin
      if (crcFailEvt && !crcStaticSeq) crcFail_r <= 1'b1;
      else if (clrDev) crcFail_r <= 1'b0;
      if (spiInvalidEvt) spiFail_r <= 1'b1;
      else if (clrDev) spiFail_r <= 1'b0;
      if (failureEvt) failure_r <= 1'b1;
      else if (clrDev) failure_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prior_r <= DBS_PRIOR_CLEARED;
    end else if (softReset) begin
      prior_r <= DBS_PRIOR_CLEARED;
    end else if (restartExit) begin
      prior_r <= (fromSleep || sleepWithFlags) ? DBS_PRIOR_SLEEP
                                               : DBS_PRIOR_RESTART;
    end else if (clrDev) begin
      prior_r <= DBS_PRIOR_CLEARED;
    end
  end

  // Counter is hardware-owned: only the device's own clear or a soft reset resets it
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wdCnt_r <= 2'h0;
    end else if (softReset || wdCountClr) begin
      wdCnt_r <= 2'h0;
    end else if (wdFailEvt && wdCnt_r != WD_CNT_MAX) begin
      wdCnt_r <= wdCnt_r + 2'h1;
    end
  end

  // Time-out flag with clear blocked until the interrupt pin falls
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      can_timeout_flag_r      <= 1'b0;
      toClrBlock_r <= 1'b0;
    end else if (softReset) begin
      can_timeout_flag_r      <= 1'b0;
      toClrBlock_r <= 1'b0;
    end else begin
      // Block arms only on the rising flag; a lasting silence keeps the flag set
      if (selectiveWakeEnable && canSilenceIndication && !can_timeout_flag_r) toClrBlock_r <= 1'b1;
      else if (interruptFallEvt) toClrBlock_r <= 1'b0;
      if (selectiveWakeEnable && canSilenceIndication) can_timeout_flag_r <= 1'b1;
      else if (clrBus && !toClrBlock_r) can_timeout_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      swErr_r   <= 1'b0;
      canFail_r <= DBS_CAN_OK;
      vcanUv_r  <= 1'b0;
    end else if (softReset) begin
      swErr_r   <= 1'b0;
      canFail_r <= DBS_CAN_OK;
      vcanUv_r  <= 1'b0;
    end else begin
      if (selectiveWakeEnable && (swkConfigErr || swkErrCount > SWK_ERR_LIMIT))
        swErr_r <= 1'b1;
      else if (clrBus) swErr_r <= 1'b0;
      if (busDomCond) canFail_r <= DBS_CAN_BUS_DOM;
      else if (txdDomCond) canFail_r <= DBS_CAN_TXD_DOM;
      else if (canTsd) canFail_r <= DBS_CAN_TSD;
      else if (clrBus) canFail_r <= DBS_CAN_OK;
      if (uvActive) vcanUv_r <= 1'b1;
      else if (clrBus) vcanUv_r <= 1'b0;
    end
  end

  // Transmitter re-enable after fault needs TXD high for the enable time
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      txState_r <= DBS_TX_OFF;
      txCnt_r   <= 8'h0;
    end else begin
      unique case (txState_r)
        DBS_TX_OFF, DBS_TX_WAIT: begin
          if (anyFault || !txdHigh) begin
            txState_r <= DBS_TX_WAIT;
            txCnt_r   <= 8'h0;
          end else if (txCnt_r >= 8'(TX_EN_CYCLES - 1)) begin
            txState_r <= DBS_TX_ENABLED;
          end else begin
            txCnt_r <= txCnt_r + 8'h1;
          end
        end
        // Ordinary traffic drives TXD low, so only a fault leaves this state
        DBS_TX_ENABLED: begin
          if (anyFault) begin
            txState_r <= DBS_TX_WAIT;
            txCnt_r   <= 8'h0;
          end
        end
        default: begin
          txState_r <= DBS_TX_WAIT;
          txCnt_r   <= 8'h0;
        end
      endcase
    end
  end

  property p_rsv_zero;
    @(posedge mclk) disable iff (!reset_n)
      $past(rdDev) |-> rdData[$bits(rdData) - 1:CRC_STAT_BIT + 1] == '0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits nonzero");
  property p_wd_sat;
    @(posedge mclk) disable iff (!reset_n)
      wdCnt_r == WD_CNT_MAX && !softReset && !wdCountClr |=> wdCnt_r == WD_CNT_MAX;
  endproperty
  a_wd_sat: assert property (p_wd_sat) else $error("wd count left max");
  property p_spi_set;
    @(posedge mclk) disable iff (!reset_n) spiInvalidEvt && !softReset |=> spiFail_r;
  endproperty
  a_spi_set: assert property (p_spi_set) else $error("spi fail not set");
  property p_crc_static;
    @(posedge mclk) disable iff (!reset_n)
      !crcFail_r && crcStaticSeq && !softReset |=> !crcFail_r;
  endproperty
  a_crc_static: assert property (p_crc_static) else $error("crc fail on static seq");
  property p_to_block;
    @(posedge mclk) disable iff (!reset_n)
      can_timeout_flag_r && toClrBlock_r && !interruptFallEvt && !softReset |=> can_timeout_flag_r;
  endproperty
  a_to_block: assert property (p_to_block) else $error("timeout cleared early");
  property p_to_set;
    @(posedge mclk) disable iff (!reset_n)
      selectiveWakeEnable && canSilenceIndication && !softReset |=> can_timeout_flag_r;
  endproperty
  a_to_set: assert property (p_to_set) else $error("timeout not set");
  property p_uv_tx;
    @(posedge mclk) disable iff (!reset_n) uvActive |-> !canTxEnable;
  endproperty
  a_uv_tx: assert property (p_uv_tx) else $error("tx on in undervoltage");
  property p_prior;
    @(posedge mclk) disable iff (!reset_n)
      restartExit && !softReset && !fromSleep && !sleepWithFlags
        |=> prior_r == DBS_PRIOR_RESTART;
  endproperty
  a_prior: assert property (p_prior) else $error("prior state wrong");
  property p_tx_wait;
    @(posedge mclk) disable iff (!reset_n) $rose(canTxEnable) |-> $past(txdHigh, 1);
  endproperty
  a_tx_wait: assert property (p_tx_wait) else $error("tx enabled without txd high");
  property p_irq;
    @(posedge mclk) disable iff (!reset_n)
      can_timeout_flag_r && canTimeoutIrqMask && normalOrStop |-> canTimeoutIrq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");
  property p_restart_keep;
    @(posedge mclk) disable iff (!reset_n)
      restartReset && !softReset && !restartExit && !clrDev && !wdFailEvt && !wdCountClr
        |=> prior_r == $past(prior_r) && wdCnt_r == $past(wdCnt_r);
  endproperty
  a_restart_keep: assert property (p_restart_keep) else $error("restart lost fields");
  property p_bus_dom;
    @(posedge mclk) disable iff (!reset_n)
      busDomCond && !softReset |=> canFail_r == DBS_CAN_BUS_DOM;
  endproperty
  a_bus_dom: assert property (p_bus_dom) else $error("bus dominant code missing");
  property p_rd_clr;
    @(posedge mclk) disable iff (!reset_n)
      rdDev && !spiInvalidEvt && !softReset |=> !spiFail_r;
  endproperty
  a_rd_clr: assert property (p_rd_clr) else $error("spi fail kept after read");

  c_timeout: cover property (@(posedge mclk) disable iff (!reset_n) $rose(can_timeout_flag_r));
  c_wd_max: cover property (@(posedge mclk) disable iff (!reset_n) wdCnt_r == WD_CNT_MAX);
  c_tx_back: cover property (@(posedge mclk) disable iff (!reset_n) $rose(canTxEnable));
  c_sleep: cover property (@(posedge mclk) disable iff (!reset_n) prior_r == DBS_PRIOR_SLEEP);

endmodule : dbs_status_regs

// [verification/dbs_host_model.sv]
`timescale 1ns/1ps
module dbs_host_model (
  // Clock and read answer
  input  wire logic        mclk,
  input  wire logic [15:0] rdData,
  input  wire logic        crcCheckSkip,
  // Read and clear requests
  output logic             rdStb,
  output logic      [6:0]  rdAddr,
  output logic             spiClrStb
);
  initial begin
    rdStb     = 1'b0;
    rdAddr    = 7'h00;
    spiClrStb = 1'b0;
  end

  // Entered just after an edge; request held to the taking edge, then an idle edge follows
  task automatic access(input logic [6:0] a, input logic clr, output logic [15:0] d,
                        output logic sk);
    rdAddr    = a;
    rdStb     = ~clr;
    spiClrStb = clr;
    #1 sk = crcCheckSkip;
    @(posedge mclk);
    #1 d = rdData;
    rdStb     = 1'b0;
    spiClrStb = 1'b0;
    // Released address shows a changed pattern, not the last value
    rdAddr    = ~a;
    @(posedge mclk);
    #1;
  endtask : access
endmodule : dbs_host_model

// [verification/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import dbs_pkg::*;
  typedef struct packed {
    logic [6:0]  a;
    logic [19:0] ev;
    logic [5:0]  cnt;
    logic        hold;
    logic [15:0] e1;
    logic [15:0] e2;
  } dbs_row_t;
  logic        mclk = 1'b0, reset_n = 1'b0, softReset = 1'b0, restartReset = 1'b0;
  logic        wdCountClr = 1'b0, mask = 1'b1, normalOrStop = 1'b1, fallEvt = 1'b0;
  logic        txdHigh = 1'b0;
  logic [19:0] ev = '0;
  logic [5:0]  cnt = '0;
  logic        rdStb, spiClrStb, crcCheckSkip, canTimeoutIrq, canTxEnable, sk;
  logic [6:0]  rdAddr;
  logic [15:0] rdData, got;
  int          errTotal = 0, compares = 0, cycles = 0;
  dbs_row_t    r;
  localparam int TxEn = 2;
  // Event bits: 0 crc on,1 crc fail,2 static seq,3 failure,4 spi bad,5 wd,6 dev mode,
  // 7 restart exit,8 from sleep,9 sleep w/ flags,10 swk on,11 silence,12 cfg err,
  // 13 tsd,14 txd dom,15 bus dom,16 supply low,17 normal/rx-only,18 bus recessive,
  // 19 wake-capable/off
  dbs_row_t rows[23] = '{
    '{7'h42, 20'h00001, 6'h00, 1'b1, 16'h0200, 16'h0000},
    '{7'h42, 20'h00002, 6'h00, 1'b0, 16'h0100, 16'h0000},
    '{7'h42, 20'h00006, 6'h00, 1'b0, 16'h0000, 16'h0000},
    '{7'h42, 20'h00008, 6'h00, 1'b0, 16'h0001, 16'h0000},
    '{7'h42, 20'h00010, 6'h00, 1'b0, 16'h0002, 16'h0000},
    '{7'h42, 20'h00040, 6'h00, 1'b1, 16'h0010, 16'h0000},
    '{7'h42, 20'h00080, 6'h00, 1'b0, 16'h0040, 16'h0000},
    '{7'h42, 20'h00180, 6'h00, 1'b0, 16'h0080, 16'h0000},
    '{7'h42, 20'h00280, 6'h00, 1'b0, 16'h0080, 16'h0000},
    '{7'h43, 20'h00800, 6'h00, 1'b0, 16'h0000, 16'h0000},
    '{7'h43, 20'h01000, 6'h00, 1'b0, 16'h0000, 16'h0000},
    '{7'h43, 20'h01400, 6'h00, 1'b0, 16'h0008, 16'h0000},
    '{7'h43, 20'h00400, 6'h20, 1'b0, 16'h0000, 16'h0000},
    '{7'h43, 20'h00400, 6'h21, 1'b0, 16'h0008, 16'h0000},
    '{7'h43, 20'h02000, 6'h00, 1'b0, 16'h0002, 16'h0000},
    '{7'h43, 20'h04000, 6'h00, 1'b0, 16'h0004, 16'h0000},
    '{7'h43, 20'h08000, 6'h00, 1'b0, 16'h0006, 16'h0000},
    '{7'h43, 20'h10000, 6'h00, 1'b0, 16'h0000, 16'h0000},
    '{7'h43, 20'h30000, 6'h00, 1'b0, 16'h0001, 16'h0000},
    '{7'h43, 20'h48000, 6'h00, 1'b0, 16'h0000, 16'h0000},
    '{7'h43, 20'h84000, 6'h00, 1'b0, 16'h0000, 16'h0000},
    '{7'h44, 20'h00000, 6'h00, 1'b0, 16'h0000, 16'h0000},
    '{7'h43, 20'h00c00, 6'h00, 1'b0, 16'h0010, 16'h0010}
  };

  dbs_status_regs #(.TX_EN_CYCLES(TxEn)) dut (
    .mclk(mclk), .reset_n(reset_n), .softReset(softReset), .restartReset(restartReset),
    .rdStb(rdStb), .rdAddr(rdAddr), .spiClrStb(spiClrStb), .rdData(rdData),
    .crcCheckSkip(crcCheckSkip), .crcEnabled(ev[0]), .crcFailEvt(ev[1]),
    .crcStaticSeq(ev[2]), .failureEvt(ev[3]), .spiInvalidEvt(ev[4]), .wdFailEvt(ev[5]),
    .wdCountClr(wdCountClr), .devModeActive(ev[6]), .restartExit(ev[7]),
    .fromSleep(ev[8]), .sleepWithFlags(ev[9]), .selectiveWakeEnable(ev[10]),
    .canSilenceIndication(ev[11]), .canTimeoutIrqMask(mask), .normalOrStop(normalOrStop),
    .swkConfigErr(ev[12]), .swkErrCount(cnt), .canTsd(ev[13]), .txdDomTimeout(ev[14]),
    .busDomTimeout(ev[15]), .txdHigh(txdHigh), .busRecessive(ev[18]),
    .canNormalOrRxOnly(ev[17]), .canWakeOrOff(ev[19]), .canSupplyBelowThr(ev[16]),
    .interruptFallEvt(fallEvt), .canTimeoutIrq(canTimeoutIrq), .canTxEnable(canTxEnable)
  );

  dbs_host_model host (
    .mclk(mclk), .rdData(rdData), .crcCheckSkip(crcCheckSkip),
    .rdStb(rdStb), .rdAddr(rdAddr), .spiClrStb(spiClrStb)
  );

  always #20 mclk = ~mclk;

  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      errTotal++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk16

  task automatic chk1(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      errTotal++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk1

  task automatic tick;
    @(posedge mclk);
    #1;
  endtask : tick

  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    host.access(a, 1'b0, got, sk);
    chk1(sk, a == DEV_INFO_ADDR);
    chk16(got, e);
  endtask : rd

  task automatic finishTest;
    $display("comparisons=%0d mismatches=%0d", compares, errTotal);
    if (errTotal == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finishTest

  // Ceiling well above the roughly two hundred cycles the sequence needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      errTotal++;
      finishTest();
    end
  end

  initial begin
    repeat (2) @(posedge mclk);
    #1;
    chk1(canTxEnable, 1'b0);
    reset_n = 1'b1;
    tick;
    rd(DEV_INFO_ADDR, 16'h0000);
    rd(BUS_COMM_ADDR, 16'h0000);
    foreach (rows[i]) begin
      tick;
      r   = rows[i];
      ev  = r.ev;
      cnt = r.cnt;
      tick;
      if (!r.hold) ev = '0;
      cnt = '0;
      rd(r.a, r.e1);
      if (r.hold) ev = '0;
      rd(r.a, r.e2);
    end
    chk1(canTimeoutIrq, 1'b1);
    normalOrStop = 1'b0;
    tick;
    chk1(canTimeoutIrq, 1'b0);
    normalOrStop = 1'b1;
    mask = 1'b0;
    tick;
    chk1(canTimeoutIrq, 1'b0);
    fallEvt = 1'b1;
    tick;
    fallEvt = 1'b0;
    rd(BUS_COMM_ADDR, 16'h0010);
    // Unmapped read right after a non-zero word must not repeat it
    rd(7'h44, 16'h0000);
    rd(BUS_COMM_ADDR, 16'h0000);
    ev = 20'h00010;
    tick;
    ev = '0;
    host.access(DEV_INFO_ADDR, 1'b1, got, sk);
    rd(DEV_INFO_ADDR, 16'h0000);
    for (int i = 1; i <= 4; i++) begin
      ev = 20'h00020;
      tick;
      ev = '0;
      rd(DEV_INFO_ADDR, 16'(((i > 3) ? 3 : i) << 2));
    end
    ev = 20'h00010;
    restartReset = 1'b1;
    tick;
    ev = '0;
    restartReset = 1'b0;
    rd(DEV_INFO_ADDR, 16'h000e);
    softReset = 1'b1;
    tick;
    softReset = 1'b0;
    rd(DEV_INFO_ADDR, 16'h0000);
    ev = 20'h00020;
    tick;
    ev = '0;
    wdCountClr = 1'b1;
    tick;
    wdCountClr = 1'b0;
    rd(DEV_INFO_ADDR, 16'h0000);
    ev = 20'h22000;
    tick;
    ev = 20'h20000;
    repeat (3) tick;
    chk1(canTxEnable, 1'b0);
    // Controller holds transmit data recessive while waiting for re-enable
    txdHigh = 1'b1;
    repeat (TxEn - 1) begin
      tick;
      chk1(canTxEnable, 1'b0);
    end
    tick;
    chk1(canTxEnable, 1'b1);
    ev = 20'h30000;
    repeat (2) tick;
    chk1(canTxEnable, 1'b0);
    ev = 20'h00008;
    tick;
    ev = '0;
    // Power-on style reset in mid-run must wipe a pending flag
    reset_n = 1'b0;
    tick;
    reset_n = 1'b1;
    tick;
    rd(DEV_INFO_ADDR, 16'h0000);
    finishTest();
  end
endmodule : tb_top
